// >>> rtl/adc_status_fuse_check_regs.sv
// Status, fuse check and threshold capture registers of the converter.
`timescale 1ns/1ps
module adc_status_fuse_check_regs #(
	parameter int FUSE_WORDS     = status_regs_pkg::FUSE_WORDS,
	parameter int STARTUP_CYCLES = status_regs_pkg::STARTUP_CYCLES,
	parameter int IF_STATUS_W    = 8
) (
	input  wire logic                    CLK_SYS,
	input  wire logic                    RSTN,
	input  wire logic [7:0]              REG_ADDR,
	input  wire logic                    REG_WR,
	input  wire logic [7:0]              REG_WDATA,
	input  wire logic                    REG_RD,
	output logic      [7:0]              REG_RDATA,
	input  wire logic [FUSE_WORDS*8-1:0] FUSE_MAP,
	input  wire logic [7:0]              FUSE_CRC_REF,
	input  wire logic [IF_STATUS_W-1:0]  INTERFACE_STATUS,
	input  wire logic                    LIMIT_OVERRUN_EVENT,
	input  wire logic                    UPPER_ALERT_EVENT,
	input  wire logic                    LOWER_ALERT_EVENT,
	input  wire logic                    ABOVE_RANGE_EVENT,
	input  wire logic                    BELOW_RANGE_EVENT,
	input  wire logic                    TRIGGER_MODE,
	input  wire logic                    TWOS_COMPLEMENT_SEL,
	input  wire logic [15:0]             CONV_RESULT,
	output logic                         DEVICE_READY_OUT,
	output logic                         FUSE_CHECK_BUSY
);
	localparam int SW = $clog2(STARTUP_CYCLES + 1);

	logic          start_q, start_d;
	logic          fail_q, fail_d;
	logic          ready_q, ready_d;
	logic [SW-1:0] boot_q, boot_d;
	logic          reset_seen_q, reset_seen_d;
	logic          overrun_q, overrun_d;
	logic          upper_q, upper_d;
	logic          lower_q, lower_d;
	logic          above_q, above_d;
	logic          below_q, below_d;
	logic [15:0]   upper_cap_q, upper_cap_d;
	logic [15:0]   lower_cap_q, lower_cap_d;
	logic [7:0]    rdata_q, rdata_d;
	logic          crc_busy, crc_done, crc_fail;
	logic          wr_fuse, wr_flags, launch;
	logic [15:0]   coded;

	assign wr_fuse  = REG_WR &&
		(REG_ADDR == status_regs_pkg::FUSE_CHECK_CONTROL_ADDR);
	assign wr_flags = REG_WR &&
		(REG_ADDR == status_regs_pkg::DEVICE_STATE_FLAGS_ADDR);
	// A second start while a check runs is absorbed by the running check.
	assign launch = wr_fuse && REG_WDATA[status_regs_pkg::FUSE_START_BIT]
		&& !start_q;

	fuse_crc_engine #(
		.WORDS(FUSE_WORDS)
	) fuse_crc_engine_i (
		.clk         (CLK_SYS),
		.rst_n       (RSTN),
		.start       (launch),
		.fuse_map    (FUSE_MAP),
		.expected_crc(FUSE_CRC_REF),
		.busy        (crc_busy),
		.done        (crc_done),
		.fail        (crc_fail)
	);

	// The converter core delivers offset binary; the coding select flips
	// the sign bit so captures match the normal conversion output.
	assign coded = TWOS_COMPLEMENT_SEL ?
		{~CONV_RESULT[15], CONV_RESULT[14:0]} : CONV_RESULT;

	always_comb begin
		start_d = start_q;
		if (launch) begin
			start_d = 1'b1;
		end else if (crc_done) begin
			start_d = 1'b0;
		end
		// Set wins over a clear arriving in the same cycle.
		fail_d = fail_q;
		if (wr_fuse && REG_WDATA[status_regs_pkg::FUSE_FAIL_BIT]) begin
			fail_d = 1'b0;
		end
		if (crc_done && crc_fail) begin
			fail_d = 1'b1;
		end
	end

	always_comb begin
		boot_d  = boot_q;
		ready_d = ready_q;
		if (!ready_q) begin
			if (boot_q == SW'(STARTUP_CYCLES - 1)) begin
				ready_d = 1'b1;
			end else begin
				boot_d = boot_q + SW'(1);
			end
		end
		reset_seen_d = reset_seen_q &&
			!(wr_flags && REG_WDATA[status_regs_pkg::RESET_SEEN_BIT]);
		overrun_d = LIMIT_OVERRUN_EVENT || (overrun_q &&
			!(wr_flags && REG_WDATA[status_regs_pkg::OVERRUN_BIT]));
		upper_d = UPPER_ALERT_EVENT || (upper_q &&
			!(wr_flags && REG_WDATA[status_regs_pkg::UPPER_ALERT_BIT]));
		lower_d = LOWER_ALERT_EVENT || (lower_q &&
			!(wr_flags && REG_WDATA[status_regs_pkg::LOWER_ALERT_BIT]));
		above_d = ABOVE_RANGE_EVENT || (above_q &&
			!(wr_flags && REG_WDATA[status_regs_pkg::ABOVE_RANGE_BIT]));
		below_d = BELOW_RANGE_EVENT || (below_q &&
			!(wr_flags && REG_WDATA[status_regs_pkg::BELOW_RANGE_BIT]));
	end

	always_comb begin
		upper_cap_d = upper_cap_q;
		lower_cap_d = lower_cap_q;
		if (TRIGGER_MODE && UPPER_ALERT_EVENT) begin
			upper_cap_d = coded;
		end
		if (TRIGGER_MODE && LOWER_ALERT_EVENT) begin
			lower_cap_d = coded;
		end
	end

	always_comb begin
		rdata_d = rdata_q;
		if (REG_RD) begin
			case (REG_ADDR)
				status_regs_pkg::FUSE_CHECK_CONTROL_ADDR: begin
					rdata_d = 8'h00;
					rdata_d[status_regs_pkg::FUSE_START_BIT] = start_q;
					rdata_d[status_regs_pkg::FUSE_FAIL_BIT]  = fail_q;
				end
				status_regs_pkg::DEVICE_STATE_FLAGS_ADDR: begin
					rdata_d = 8'h00;
					rdata_d[status_regs_pkg::READY_BIT]       = ready_q;
					rdata_d[status_regs_pkg::RESET_SEEN_BIT]  = reset_seen_q;
					rdata_d[status_regs_pkg::IF_ERR_BIT]      =
						|INTERFACE_STATUS;
					rdata_d[status_regs_pkg::OVERRUN_BIT]     = overrun_q;
					rdata_d[status_regs_pkg::UPPER_ALERT_BIT] = upper_q;
					rdata_d[status_regs_pkg::LOWER_ALERT_BIT] = lower_q;
					rdata_d[status_regs_pkg::ABOVE_RANGE_BIT] = above_q;
					rdata_d[status_regs_pkg::BELOW_RANGE_BIT] = below_q;
				end
				status_regs_pkg::UPPER_ALERT_CAPTURE_LO:
					rdata_d = upper_cap_q[7:0];
				status_regs_pkg::UPPER_ALERT_CAPTURE_HI:
					rdata_d = upper_cap_q[15:8];
				status_regs_pkg::LOWER_ALERT_CAPTURE_LO:
					rdata_d = lower_cap_q[7:0];
				status_regs_pkg::LOWER_ALERT_CAPTURE_HI:
					rdata_d = lower_cap_q[15:8];
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			start_q      <= 1'b0;
			fail_q       <= 1'b0;
			ready_q      <= 1'b0;
			boot_q       <= '0;
			reset_seen_q <= 1'b1;
			overrun_q    <= 1'b0;
			upper_q      <= 1'b0;
			lower_q      <= 1'b0;
			above_q      <= 1'b0;
			below_q      <= 1'b0;
			upper_cap_q  <= status_regs_pkg::CAPTURE_RST;
			lower_cap_q  <= status_regs_pkg::CAPTURE_RST;
			rdata_q      <= 8'h00;
		end else begin
			start_q      <= start_d;
			fail_q       <= fail_d;
			ready_q      <= ready_d;
			boot_q       <= boot_d;
			reset_seen_q <= reset_seen_d;
			overrun_q    <= overrun_d;
			upper_q      <= upper_d;
			lower_q      <= lower_d;
			above_q      <= above_d;
			below_q      <= below_d;
			upper_cap_q  <= upper_cap_d;
			lower_cap_q  <= lower_cap_d;
			rdata_q      <= rdata_d;
		end
	end

	assign REG_RDATA        = rdata_q;
	assign DEVICE_READY_OUT = ready_q;
	assign FUSE_CHECK_BUSY  = start_q | crc_busy;
endmodule : adc_status_fuse_check_regs

// >>> rtl/status_regs_pkg.sv
// Package with the register map, field positions and timing of the status bank.
package status_regs_pkg;

	localparam logic [7:0] FUSE_CHECK_CONTROL_ADDR  = 8'h40;
	localparam logic [7:0] DEVICE_STATE_FLAGS_ADDR  = 8'h41;
	localparam logic [7:0] UPPER_ALERT_CAPTURE_LO   = 8'h42;
	localparam logic [7:0] UPPER_ALERT_CAPTURE_HI   = 8'h43;
	localparam logic [7:0] LOWER_ALERT_CAPTURE_LO   = 8'h44;
	localparam logic [7:0] LOWER_ALERT_CAPTURE_HI   = 8'h45;

	localparam logic [7:0] FUSE_CHECK_CONTROL_RST   = 8'h00;
	localparam logic [7:0] DEVICE_STATE_FLAGS_RST   = 8'h40;
	localparam logic [15:0] CAPTURE_RST             = 16'h0000;

	localparam int FUSE_START_BIT   = 0;
	localparam int FUSE_FAIL_BIT    = 1;
	localparam int READY_BIT        = 7;
	localparam int RESET_SEEN_BIT   = 6;
	localparam int IF_ERR_BIT       = 5;
	localparam int OVERRUN_BIT      = 4;
	localparam int UPPER_ALERT_BIT  = 3;
	localparam int LOWER_ALERT_BIT  = 2;
	localparam int ABOVE_RANGE_BIT  = 1;
	localparam int BELOW_RANGE_BIT  = 0;

	localparam int FUSE_WORDS       = 16;
	localparam int STARTUP_CYCLES   = 16;
	localparam logic [7:0] CRC_INIT = 8'hff;
	localparam logic [7:0] CRC_POLY = 8'h07;

endpackage : status_regs_pkg

// >>> rtl/fuse_crc_engine.sv
// Walks the fuse map one word per cycle and checks its CRC-8.
`timescale 1ns/1ps
module fuse_crc_engine #(
	parameter int WORDS = status_regs_pkg::FUSE_WORDS
) (
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	input  wire logic                     start,
	input  wire logic [WORDS*8-1:0]       fuse_map,
	input  wire logic [7:0]               expected_crc,
	output logic                          busy,
	output logic                          done,
	output logic                          fail
);
	typedef enum logic [1:0] {IDLE, RUN, FINISH} crc_state_t;
	localparam int IW = $clog2(WORDS + 1);

	crc_state_t      state_q, state_d;
	logic [IW-1:0]   idx_q, idx_d;
	logic [7:0]      crc_q, crc_d;
	logic            done_q, done_d;
	logic            fail_q, fail_d;

	function automatic logic [7:0] crc_byte(input logic [7:0] c,
		input logic [7:0] b);
		logic [7:0] r;
		r = c ^ b;
		for (int i = 0; i < 8; i++) begin
			r = r[7] ? ((r << 1) ^ status_regs_pkg::CRC_POLY) : (r << 1);
		end
		return r;
	endfunction : crc_byte

	always_comb begin
		state_d = state_q;
		idx_d   = idx_q;
		crc_d   = crc_q;
		done_d  = 1'b0;
		fail_d  = 1'b0;
		case (state_q)
			IDLE: begin
				if (start) begin
					idx_d   = '0;
					crc_d   = status_regs_pkg::CRC_INIT;
					state_d = RUN;
				end
			end
			RUN: begin
				crc_d = crc_byte(crc_q, fuse_map[idx_q*8 +: 8]);
				idx_d = idx_q + IW'(1);
				if (idx_q == IW'(WORDS - 1)) begin
					state_d = FINISH;
				end
			end
			FINISH: begin
				done_d  = 1'b1;
				fail_d  = (crc_q != expected_crc);
				state_d = IDLE;
			end
			default: state_d = IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= IDLE;
			idx_q   <= '0;
			crc_q   <= 8'h00;
			done_q  <= 1'b0;
			fail_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			idx_q   <= idx_d;
			crc_q   <= crc_d;
			done_q  <= done_d;
			fail_q  <= fail_d;
		end
	end

	assign busy = (state_q != IDLE);
	assign done = done_q;
	assign fail = fail_q;
endmodule : fuse_crc_engine

// >>> dv/status_regs_checker_assertions.sv
// Port-level assertions for the status and fuse check register bank.
`timescale 1ns/1ps
module status_regs_checker #(
	parameter int FUSE_WORDS  = 16,
	parameter int IF_STATUS_W = 8
) (
	input wire logic                   CLK_SYS,
	input wire logic                   RSTN,
	input wire logic [7:0]             REG_ADDR,
	input wire logic                   REG_WR,
	input wire logic [7:0]             REG_WDATA,
	input wire logic                   REG_RD,
	input wire logic [7:0]             REG_RDATA,
	input wire logic [IF_STATUS_W-1:0] INTERFACE_STATUS,
	input wire logic                   LIMIT_OVERRUN_EVENT,
	input wire logic                   UPPER_ALERT_EVENT,
	input wire logic                   TRIGGER_MODE,
	input wire logic                   TWOS_COMPLEMENT_SEL,
	input wire logic [15:0]            CONV_RESULT,
	input wire logic                   DEVICE_READY_OUT,
	input wire logic                   FUSE_CHECK_BUSY
);
	logic [7:0] bcnt_q, bcnt_d, cap_q, cap_d;
	wire        rd40 = REG_RD && REG_ADDR == 8'h40;
	wire        rd41 = REG_RD && REG_ADDR == 8'h41;
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RSTN);
	// Only the upper capture's high byte is mirrored, where the coding shows.
	always_comb begin
		bcnt_d = FUSE_CHECK_BUSY ? bcnt_q + 8'h01 : 8'h00;
		cap_d  = cap_q;
		if (TRIGGER_MODE && UPPER_ALERT_EVENT)
			cap_d = {CONV_RESULT[15] ^ TWOS_COMPLEMENT_SEL, CONV_RESULT[14:8]};
	end
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			bcnt_q <= 8'h00;
			cap_q  <= 8'h00;
		end else begin
			bcnt_q <= bcnt_d;
			cap_q  <= cap_d;
		end
	end
	property p_start_run;
		REG_WR && REG_ADDR == 8'h40 && REG_WDATA[0] && !FUSE_CHECK_BUSY
			|=> FUSE_CHECK_BUSY;
	endproperty
	a_start_run: assert property (p_start_run)
		else $error("fuse check did not start");
	property p_busy_len;
		$fell(FUSE_CHECK_BUSY) |-> bcnt_q == 8'(FUSE_WORDS + 2);
	endproperty
	a_busy_len: assert property (p_busy_len)
		else $error("fuse check length wrong");
	property p_rsv_zero;
		rd40 |=> REG_RDATA[7:2] == 6'h00;
	endproperty
	a_rsv_zero: assert property (p_rsv_zero)
		else $error("reserved bits not zero");
	property p_unmapped;
		REG_RD && REG_ADDR > 8'h45 |=> REG_RDATA == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	property p_if_err;
		rd41 |=> REG_RDATA[5] == |$past(INTERFACE_STATUS);
	endproperty
	a_if_err: assert property (p_if_err)
		else $error("interface error bit wrong");
	property p_ready;
		rd41 |=> REG_RDATA[7] == $past(DEVICE_READY_OUT);
	endproperty
	a_ready: assert property (p_ready)
		else $error("ready bit differs from ready output");
	property p_overrun;
		LIMIT_OVERRUN_EVENT ##1 !REG_WR ##1 rd41 |=> REG_RDATA[4];
	endproperty
	a_overrun: assert property (p_overrun)
		else $error("overrun flag not held");
	property p_cap_hi;
		REG_RD && REG_ADDR == 8'h43 |=> REG_RDATA == $past(cap_q);
	endproperty
	a_cap_hi: assert property (p_cap_hi)
		else $error("upper capture wrong");
	c_done: cover property ($fell(FUSE_CHECK_BUSY));
	c_ready: cover property ($rose(DEVICE_READY_OUT));
	c_cap: cover property (TRIGGER_MODE && REG_RD && REG_ADDR == 8'h43);
endmodule : status_regs_checker
bind adc_status_fuse_check_regs status_regs_checker #(
	.FUSE_WORDS(FUSE_WORDS), .IF_STATUS_W(IF_STATUS_W)) status_regs_checker_i (
	.CLK_SYS, .RSTN, .REG_ADDR, .REG_WR, .REG_WDATA, .REG_RD, .REG_RDATA,
	.INTERFACE_STATUS, .LIMIT_OVERRUN_EVENT, .UPPER_ALERT_EVENT, .TRIGGER_MODE,
	.TWOS_COMPLEMENT_SEL, .CONV_RESULT, .DEVICE_READY_OUT, .FUSE_CHECK_BUSY);

// >>> dv/reg_host.sv
// Host model issuing single byte reads and writes to the register bank.
`timescale 1ns/1ps
module reg_host (
	input  wire logic       clk,
	input  wire logic [7:0] rdata,
	output logic      [7:0] addr,
	output logic            wr,
	output logic      [7:0] wdata,
	output logic            rd
);
	initial begin
		addr  = 8'h00;
		wr    = 1'b0;
		wdata = 8'h00;
		rd    = 1'b0;
	end
	// Released lines show inverted values so a stale sample cannot pass.
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
		addr  <= ~a;
		wdata <= ~d;
		#1;
	endtask : put
	task automatic get(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		addr <= ~a;
		#1 d = rdata;
	endtask : get
endmodule : reg_host

// >>> dv/adc_status_fuse_check_regs_tb_top.sv
// Self-checking bench for the status and fuse check register bank.
`timescale 1ns/1ps
module adc_status_fuse_check_regs_tb_top;
	localparam int NW = 4;
	logic            clk_sys = 1'b0;
	logic            rstn = 1'b0;
	logic [7:0]      addr, wdata, rdata, d, crc_ref = 8'h00, if_st = 8'h00;
	logic            wr, rd, busy, ready, trig = 1'b0, sel = 1'b0;
	logic [4:0]      ev = 5'h00;
	logic [15:0]     conv = 16'h0000;
	logic [NW*8-1:0] fmap = 32'h3c5a96e1;
	int              n_fail = 0, cmp_count = 0, cyc = 0;
	always #20 clk_sys = ~clk_sys;
	reg_host reg_host_i (.clk(clk_sys), .rdata(rdata), .addr(addr), .wr(wr),
		.wdata(wdata), .rd(rd));
	adc_status_fuse_check_regs #(.FUSE_WORDS(NW), .STARTUP_CYCLES(4))
	adc_status_fuse_check_regs_i (.CLK_SYS(clk_sys), .RSTN(rstn),
		.REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata), .REG_RD(rd),
		.REG_RDATA(rdata), .FUSE_MAP(fmap), .FUSE_CRC_REF(crc_ref),
		.INTERFACE_STATUS(if_st), .LIMIT_OVERRUN_EVENT(ev[4]),
		.UPPER_ALERT_EVENT(ev[3]), .LOWER_ALERT_EVENT(ev[2]),
		.ABOVE_RANGE_EVENT(ev[1]), .BELOW_RANGE_EVENT(ev[0]),
		.TRIGGER_MODE(trig), .TWOS_COMPLEMENT_SEL(sel), .CONV_RESULT(conv),
		.DEVICE_READY_OUT(ready), .FUSE_CHECK_BUSY(busy));
	function automatic logic [7:0] crc8(input logic [NW*8-1:0] m);
		logic [7:0] c;
		logic       fb;
		c = 8'hff;
		for (int i = 0; i < NW*8; i++) begin
			fb = c[7] ^ m[i/8*8 + 7 - i%8];
			c  = {c[6:0], 1'b0} ^ (fb ? 8'h07 : 8'h00);
		end
		return c;
	endfunction : crc8
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		reg_host_i.get(a, d);
		cmp_count++;
		if (d !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, d, exp);
		end
	endtask : rchk
	task automatic do_reset;
		@(posedge clk_sys);
		rstn <= 1'b0;
		repeat (5) @(posedge clk_sys);
		rstn <= 1'b1;
	endtask : do_reset
	task automatic t_startup;
		rchk(8'h41, 8'h40);
		for (int a = 8'h42; a < 8'h46; a++) rchk(8'(a), 8'h00);
		repeat (40) if (ready !== 1'b1) @(posedge clk_sys);
		rchk(8'h41, 8'hc0);
		reg_host_i.put(8'h41, 8'h40);
		rchk(8'h41, 8'h80);
		rchk(8'h57, 8'h00);
	endtask : t_startup
	task automatic t_flags;
		for (int b = 0; b < 5; b++) begin
			@(posedge clk_sys) ev <= 5'(1 << b);
			@(posedge clk_sys) ev <= 5'h00;
			rchk(8'h41, 8'h80 | 8'(1 << b));
			reg_host_i.put(8'h41, 8'h00);
			rchk(8'h41, 8'h80 | 8'(1 << b));
			reg_host_i.put(8'h41, 8'(1 << b));
			rchk(8'h41, 8'h80);
		end
		@(posedge clk_sys) if_st <= 8'h10;
		reg_host_i.put(8'h41, 8'h20);
		rchk(8'h41, 8'ha0);
		@(posedge clk_sys) if_st <= 8'h00;
		rchk(8'h41, 8'h80);
	endtask : t_flags
	task automatic t_capture;
		for (int s = 0; s < 2; s++) begin
			@(posedge clk_sys);
			trig <= 1'b1;
			sel  <= 1'(s);
			conv <= 16'h8a5c ^ 16'(s);
			ev   <= 5'h0c;
			@(posedge clk_sys);
			ev   <= 5'h00;
			rchk(8'h42, 8'h5c ^ 8'(s));
			rchk(8'h43, 8'h8a ^ 8'(s << 7));
			rchk(8'h44, 8'h5c ^ 8'(s));
			rchk(8'h45, 8'h8a ^ 8'(s << 7));
		end
		reg_host_i.put(8'h44, 8'hff);
		@(posedge clk_sys);
		trig <= 1'b0;
		conv <= 16'h1234;
		ev   <= 5'h0c;
		@(posedge clk_sys) ev <= 5'h00;
		rchk(8'h42, 8'h5d);
		rchk(8'h44, 8'h5d);
	endtask : t_capture
	task automatic t_fuse;
		@(posedge clk_sys) crc_ref <= crc8(fmap);
		reg_host_i.put(8'h40, 8'h01);
		repeat (40) if (busy === 1'b1) @(posedge clk_sys);
		rchk(8'h40, 8'h00);
		@(posedge clk_sys) crc_ref <= crc8(fmap) ^ 8'h01;
		reg_host_i.put(8'h40, 8'h01);
		reg_host_i.put(8'h40, 8'h01);
		repeat (40) if (busy === 1'b1) @(posedge clk_sys);
		rchk(8'h40, 8'h02);
		reg_host_i.put(8'h40, 8'hfc);
		rchk(8'h40, 8'h02);
		reg_host_i.put(8'h40, 8'h02);
		rchk(8'h40, 8'h00);
		do_reset();
		rchk(8'h41, 8'h40);
	endtask : t_fuse
	// The ceiling is far above the fewer than two hundred cycles the tests need.
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			print_verdict();
		end
	end
	initial begin
		do_reset();
		t_startup();
		t_flags();
		t_capture();
		t_fuse();
		print_verdict();
	end
endmodule : adc_status_fuse_check_regs_tb_top
